// File: shared/scan_pkg.sv
// constants and types for the boundary scan test port
package scan_pkg;
  localparam int IR_WIDTH  = 3;
  localparam int ID_WIDTH  = 32;
  localparam int BSR_WIDTH = 70;

  localparam logic [2:0] INS_CAPTURE_HIZ = 3'h0;
  localparam logic [2:0] INS_IDENT       = 3'h1;
  localparam logic [2:0] INS_SAMPLE_HIZ  = 3'h2;
  localparam logic [2:0] INS_SAMPLE      = 3'h4;
  localparam logic [2:0] INS_BYPASS      = 3'h7;
  localparam logic [2:0] IR_CAPTURE_VAL  = 3'h1;

  // identification word field positions
  localparam int ID_REV_LSB   = 28;
  localparam int ID_DEPTH_LSB = 23;
  localparam int ID_WIDTH_LSB = 18;
  localparam int ID_RSVD_LSB  = 12;
  localparam int ID_MFR_LSB   = 1;

  // register map, byte addresses
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [3:0]  CONFIG_REV_RESET  = 4'h0;
  localparam logic [5:0]  CONFIG_RSVD_RESET = 6'h00;
  localparam int CONFIG_RSVD_LSB = 4;
  localparam int STATUS_HIZ_BIT  = 3;
  localparam int STATUS_FSM_LSB  = 4;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

  // memory pads in the order of the scan chain, last field is cell 1
  typedef struct packed {
    logic       burst_bit_zero;
    logic       burst_bit_one;
    logic [3:0] addr_top;
    logic       burst_order_select;
    logic [8:0] data_lane_3;
    logic [8:0] data_lane_2;
    logic [1:0] addr_high;
    logic       chip_select_first;
    logic       chip_select_second;
    logic       byte_write_lane_3;
    logic       byte_write_lane_2;
    logic       byte_write_lane_1;
    logic       byte_write_lane_0;
    logic       chip_select_third;
    logic       mem_clock;
    logic       write_enable_low;
    logic       clock_gate_low;
    logic       output_enable_low;
    logic       load_or_advance_select;
    logic [2:0] addr_mid;
    logic [8:0] data_lane_1;
    logic       sleep_request;
    logic [8:0] data_lane_0;
    logic [6:0] addr_low;
  } pad_ring_t;

  typedef struct packed {
    logic       tck;
    logic       tms;
    logic       tdi;
  } jtag_in_t;
endpackage

// File: rtl/scan_tap.sv
// boundary scan instruction and data path with apb status access
//
// Contract
// R1 - instruction register is three bits, bypass register one bit
// R2 - identification bits 31:28 hold the revision number
// R3 - identification bits 27:23 hold the depth code
// R4 - identification bits 22:18 hold the width code
// R5 - identification bits 17:12 are a reserved field
// R6 - identification bits 11:1 hold the manufacturer code
// R7 - identification bit 0 is always one
// R8 - code 000 captures pads, selects boundary chain, forces memory outputs off
// R9 - code 001 loads identification word and selects it, memory untouched
// R10 - code 010 captures pads, selects boundary chain, forces outputs off
// R11 - code 100 captures pads, selects boundary chain, no preload, memory untouched
// R12 - controller never loads codes 011, 101 or 110; the code loads them and treats them as bypass
// R13 - code 111 selects the one-bit bypass register
// R14 - wide chain of 70 cells, address, lanes, sleep, burst cells placed
// R15 - cells 31 to 44 are the control pins, cells 30 and 54 unconnected; the code puts addr_high in cells 43 and 44
// R16 - cells 45-53 lane 2 data, 55-63 lane 3 data
// R17 - serial out changes after falling test clock, inputs sampled on rising
// R18 - capture-instruction loads 01 into the low instruction bits
// R19 - identification instruction selected at reset and test-logic-reset
// R20 - new instruction takes effect only in update-instruction
// R21 - update-data under sample has no effect beyond pause-data
// R22 - bypass captures zero in capture-data
// R23 - data registers shift lsb first, one bit per test clock
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module scan_tap #(
  parameter logic [4:0]  DEPTH_CODE = 5'h01, // arbitrary neutral value
  parameter logic [4:0]  WIDTH_CODE = 5'h02, // arbitrary neutral value
  parameter logic [10:0] MFR_CODE   = 11'h001 // arbitrary neutral value
) (
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_tck,
  input  wire logic               i_tms,
  input  wire logic               i_tdi,
  output logic                    o_tdo,
  output logic                    o_tdo_oe,
  input  wire scan_pkg::pad_ring_t i_pads,
  output logic                    o_mem_outputs_hiz,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [31:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr
);
  // two-flop synchronisers for the port pins and pads
  scan_pkg::jtag_in_t  jtag_m_q, jtag_s_q;
  scan_pkg::pad_ring_t pads_m_q, pads_s_q;
  logic                tck_prev_q;
  logic                tck_rise, tck_fall;

  scan_pkg::tap_state_t state_q, state_d;
  logic [scan_pkg::IR_WIDTH-1:0]  ir_shift_q, ir_shift_d;
  logic [scan_pkg::IR_WIDTH-1:0]  ir_active_q, ir_active_d;
  logic [scan_pkg::BSR_WIDTH-1:0] dr_q, dr_d;
  logic                           tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
  logic [3:0]                     rev_q, rev_d;
  logic [5:0]                     rsvd_q, rsvd_d;
  logic [31:0]                    prdata_q, prdata_d;
  logic                           slverr_q, slverr_d;

  logic [scan_pkg::ID_WIDTH-1:0]  id_word;
  logic [scan_pkg::BSR_WIDTH-1:0] bsr_capture;
  logic                           sel_boundary, sel_ident;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      jtag_m_q   <= '0;
      jtag_s_q   <= '0;
      pads_m_q   <= '0;
      pads_s_q   <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      jtag_m_q   <= '{tck: i_tck, tms: i_tms, tdi: i_tdi};
      jtag_s_q   <= jtag_m_q;
      pads_m_q   <= i_pads;
      pads_s_q   <= pads_m_q;
      tck_prev_q <= jtag_s_q.tck;
    end
  end

  // R17 edge detect
  assign tck_rise = jtag_s_q.tck & ~tck_prev_q;
  assign tck_fall = ~jtag_s_q.tck & tck_prev_q;

  // R2 revision field
  // R3 depth code
  // R4 width code
  // R5 reserved field
  // R6 manufacturer code
  // R7 presence bit
  assign id_word = {rev_q, DEPTH_CODE, WIDTH_CODE, rsvd_q, MFR_CODE, 1'b1};

  // R14 R15 R16 chain order, cells 30 and 54 read zero
  assign bsr_capture = {
    pads_s_q.burst_bit_zero, pads_s_q.burst_bit_one, pads_s_q.addr_top,
    pads_s_q.burst_order_select,
    pads_s_q.data_lane_3, 1'b0, pads_s_q.data_lane_2, pads_s_q.addr_high,
    pads_s_q.chip_select_first, pads_s_q.chip_select_second,
    pads_s_q.byte_write_lane_3, pads_s_q.byte_write_lane_2,
    pads_s_q.byte_write_lane_1, pads_s_q.byte_write_lane_0,
    pads_s_q.chip_select_third, pads_s_q.mem_clock, pads_s_q.write_enable_low,
    pads_s_q.clock_gate_low, pads_s_q.output_enable_low,
    pads_s_q.load_or_advance_select, 1'b0, pads_s_q.addr_mid,
    pads_s_q.data_lane_1, pads_s_q.sleep_request, pads_s_q.data_lane_0,
    pads_s_q.addr_low};

  // R8 R10 R11 boundary chain for the capturing codes
  assign sel_boundary = (ir_active_q == scan_pkg::INS_CAPTURE_HIZ) ||
                        (ir_active_q == scan_pkg::INS_SAMPLE_HIZ) ||
                        (ir_active_q == scan_pkg::INS_SAMPLE);
  assign sel_ident    = (ir_active_q == scan_pkg::INS_IDENT);

  // port controller sequencing on rising test clock
  always_comb begin
    state_d = state_q;
    if (tck_rise) begin
      unique case (state_q)
        scan_pkg::ST_RESET:  state_d = jtag_s_q.tms ? scan_pkg::ST_RESET  : scan_pkg::ST_IDLE;
        scan_pkg::ST_IDLE:   state_d = jtag_s_q.tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
        scan_pkg::ST_SEL_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_SEL_IR : scan_pkg::ST_CAP_DR;
        scan_pkg::ST_CAP_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_EX1_DR : scan_pkg::ST_SH_DR;
        scan_pkg::ST_SH_DR:  state_d = jtag_s_q.tms ? scan_pkg::ST_EX1_DR : scan_pkg::ST_SH_DR;
        scan_pkg::ST_EX1_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_UPD_DR : scan_pkg::ST_PAU_DR;
        scan_pkg::ST_PAU_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_EX2_DR : scan_pkg::ST_PAU_DR;
        scan_pkg::ST_EX2_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_UPD_DR : scan_pkg::ST_SH_DR;
        scan_pkg::ST_UPD_DR: state_d = jtag_s_q.tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
        scan_pkg::ST_SEL_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_RESET  : scan_pkg::ST_CAP_IR;
        scan_pkg::ST_CAP_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_EX1_IR : scan_pkg::ST_SH_IR;
        scan_pkg::ST_SH_IR:  state_d = jtag_s_q.tms ? scan_pkg::ST_EX1_IR : scan_pkg::ST_SH_IR;
        scan_pkg::ST_EX1_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_UPD_IR : scan_pkg::ST_PAU_IR;
        scan_pkg::ST_PAU_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_EX2_IR : scan_pkg::ST_PAU_IR;
        scan_pkg::ST_EX2_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_UPD_IR : scan_pkg::ST_SH_IR;
        scan_pkg::ST_UPD_IR: state_d = jtag_s_q.tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
        default:             state_d = scan_pkg::ST_RESET;
      endcase
    end
  end

  // instruction and data shift paths
  always_comb begin
    ir_shift_d  = ir_shift_q;
    ir_active_d = ir_active_q;
    dr_d        = dr_q;
    if (tck_rise) begin
      unique case (state_q)
        // R19 identification on test-logic-reset
        scan_pkg::ST_RESET:  ir_active_d = scan_pkg::INS_IDENT;
        // R18 capture pattern
        scan_pkg::ST_CAP_IR: ir_shift_d = scan_pkg::IR_CAPTURE_VAL;
        // R1 three-bit instruction shift
        scan_pkg::ST_SH_IR:  ir_shift_d = {jtag_s_q.tdi, ir_shift_q[2:1]};
        // R20 new instruction applied here only
        scan_pkg::ST_UPD_IR: ir_active_d = ir_shift_q;
        scan_pkg::ST_CAP_DR: begin
          // R8 R10 R11 capture pads
          if (sel_boundary) dr_d = bsr_capture;
          // R9 load identification word
          else if (sel_ident) dr_d = {{(scan_pkg::BSR_WIDTH-scan_pkg::ID_WIDTH){1'b0}}, id_word};
          // R13 R22 bypass and reserved codes capture zero
          else dr_d = '0;
        end
        scan_pkg::ST_SH_DR: begin
          // R23 lsb first, tdi enters at the selected length
          if (sel_boundary) dr_d = {jtag_s_q.tdi, dr_q[scan_pkg::BSR_WIDTH-1:1]};
          else if (sel_ident) begin
            dr_d = '0;
            dr_d[scan_pkg::ID_WIDTH-1:0] = {jtag_s_q.tdi, dr_q[scan_pkg::ID_WIDTH-1:1]};
          end else dr_d = {{(scan_pkg::BSR_WIDTH-1){1'b0}}, jtag_s_q.tdi};
        end
        // R21 update-data leaves everything as in pause
        default: ;
      endcase
      // R19 identification as soon as test-logic-reset is entered
      if (state_d == scan_pkg::ST_RESET) ir_active_d = scan_pkg::INS_IDENT;
    end
  end

  // R17 serial output moves on the falling test clock only
  always_comb begin
    tdo_d    = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      tdo_oe_d = (state_q == scan_pkg::ST_SH_DR) || (state_q == scan_pkg::ST_SH_IR);
      tdo_d    = (state_q == scan_pkg::ST_SH_IR) ? ir_shift_q[0] : dr_q[0];
    end
  end

  // apb slave: read data latched in setup, config write taken in access, zero-wait access phase
  always_comb begin
    rev_d    = rev_q;
    rsvd_d   = rsvd_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (i_psel && !i_penable) begin
      slverr_d = 1'b0;
      prdata_d = '0;
      if (i_paddr == scan_pkg::ADDR_CONFIG)
        prdata_d = {22'h0, rsvd_q, rev_q};
      else if (i_paddr == scan_pkg::ADDR_STATUS)
        prdata_d = {12'h000, state_q, o_mem_outputs_hiz, ir_active_q};
      else
        slverr_d = 1'b1;
    end
    if (i_psel && i_penable && i_pwrite && i_paddr == scan_pkg::ADDR_CONFIG) begin
      rev_d  = i_pwdata[3:0];
      rsvd_d = i_pwdata[scan_pkg::CONFIG_RSVD_LSB +: 6];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= scan_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ir_shift_q  <= scan_pkg::IR_CAPTURE_VAL;
      // R19 identification at power-up
      ir_active_q <= scan_pkg::INS_IDENT;
      dr_q        <= '0;
    end else begin
      ir_shift_q  <= ir_shift_d;
      ir_active_q <= ir_active_d;
      dr_q        <= dr_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rev_q    <= scan_pkg::CONFIG_REV_RESET;
      rsvd_q   <= scan_pkg::CONFIG_RSVD_RESET;
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      rev_q    <= rev_d;
      rsvd_q   <= rsvd_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // R8 R10 memory outputs off for the two high-impedance codes
  assign o_mem_outputs_hiz = (ir_active_q == scan_pkg::INS_CAPTURE_HIZ) ||
                             (ir_active_q == scan_pkg::INS_SAMPLE_HIZ);
  assign o_tdo     = tdo_q;
  assign o_tdo_oe  = tdo_oe_q;
  assign o_prdata  = prdata_q;
  assign o_pslverr = slverr_q & i_psel & i_penable;
  assign o_pready  = i_psel & i_penable;
endmodule

// File: verif/scan_tap_assertions.sv
// checker for the scan port pins and the status bus
`timescale 1ns/1ns
module scan_tap_assertions (
  input wire logic                i_clock,
  input wire logic                i_rst,
  input wire logic                i_tck,
  input wire logic                i_tms,
  input wire logic                i_tdi,
  input wire logic                o_tdo,
  input wire logic                o_tdo_oe,
  input wire scan_pkg::pad_ring_t i_pads,
  input wire logic                o_mem_outputs_hiz,
  input wire logic                i_psel,
  input wire logic                i_penable,
  input wire logic                i_pwrite,
  input wire logic [31:0]         i_paddr,
  input wire logic [31:0]         i_pwdata,
  input wire logic [31:0]         o_prdata,
  input wire logic                o_pready,
  input wire logic                o_pslverr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire acc = i_psel && i_penable;
  wire mapped = i_paddr == scan_pkg::ADDR_CONFIG || i_paddr == scan_pkg::ADDR_STATUS;
  sequence bus_idle;
    !i_psel ##1 !i_psel;
  endsequence
  AST_PREADY: assert property (o_pready == acc) else $error("pready outside access");
  AST_TDO_EDGE: assert property ($changed(o_tdo) |-> !i_tck && !$past(i_tck, 2))
    else $error("tdo moved while test clock high");
  AST_OE_EDGE: assert property ($changed(o_tdo_oe) |-> !i_tck)
    else $error("tdo enable moved while test clock high");
  AST_HIZ_EDGE: assert property ($changed(o_mem_outputs_hiz) |-> i_tck)
    else $error("hiz moved outside a test clock rise");
  AST_ERR_IN_ACCESS: assert property (o_pslverr |-> o_pready) else $error("stray error");
  AST_UNMAPPED: assert property (acc && !mapped |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_PRDATA_STANDS: assert property (bus_idle |-> $stable(o_prdata))
    else $error("read data moved while bus idle");
  AST_STATUS_HIZ: assert property (acc && i_paddr == scan_pkg::ADDR_STATUS |->
    o_prdata[3] == $past(o_mem_outputs_hiz) && o_prdata[3] ==
    (o_prdata[2:0] == scan_pkg::INS_CAPTURE_HIZ || o_prdata[2:0] == scan_pkg::INS_SAMPLE_HIZ))
    else $error("hiz does not follow instruction");
endmodule
bind scan_tap scan_tap_assertions scan_tap_assertions_inst (
  .i_clock(i_clock), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pads(i_pads), .o_mem_outputs_hiz(o_mem_outputs_hiz),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// File: verif/jtag_ctrl.sv
// test controller model driving the four-wire port
`timescale 1ns/1ns
module jtag_ctrl (
  input  wire logic i_clock,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // test clock idles low between steps
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // drive while low, sample tdo at the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clock);
    o_tck <= 1'b1;
    // undriven line reads inverted so a stray sample shows up
    tdo = i_tdo_oe ? i_tdo : ~i_tdo;
    repeat (4) @(posedge i_clock);
    o_tck <= 1'b0;
  endtask
endmodule

// File: verif/tb_scan_tap.sv
// self-checking bench for the scan port
`timescale 1ns/1ns
module tb_scan_tap;
  localparam logic [4:0]  DEPTH = 5'h01;   // arbitrary value
  localparam logic [4:0]  WIDTH = 5'h02;   // arbitrary value
  localparam logic [10:0] MFR   = 11'h001; // arbitrary value
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic tck, tms, tdi, tdo, tdo_oe, hiz, pready, pslverr;
  scan_pkg::pad_ring_t pads = 68'hB5A3C96E1D70F28C4;
  logic [2:0] codes [4] = '{scan_pkg::INS_CAPTURE_HIZ, scan_pkg::INS_SAMPLE_HIZ,
                            scan_pkg::INS_SAMPLE, scan_pkg::INS_BYPASS};
  int bad_count = 0;
  int check_count = 0;
  jtag_ctrl jtag_ctrl_inst (.i_clock(clock), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
                            .o_tms(tms), .o_tdi(tdi));
  scan_tap #(.DEPTH_CODE(DEPTH), .WIDTH_CODE(WIDTH), .MFR_CODE(MFR)) scan_tap_inst (
    .i_clock(clock), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_pads(pads), .o_mem_outputs_hiz(hiz), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // from idle through capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input logic [69:0] din, input int n,
                      output logic [69:0] dout);
    logic b;
    dout = '0;
    jtag_ctrl_inst.step(1'b1, 1'b0, b);
    if (ir) jtag_ctrl_inst.step(1'b1, 1'b0, b);
    jtag_ctrl_inst.step(1'b0, 1'b0, b);
    jtag_ctrl_inst.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      jtag_ctrl_inst.step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    jtag_ctrl_inst.step(1'b1, 1'b0, b);
    jtag_ctrl_inst.step(1'b0, 1'b0, b);
    check(tdo_oe, 1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run();
  end
  initial begin
    logic [69:0] d;
    logic [31:0] r;
    logic        e;
    logic        hz;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    jtag_ctrl_inst.step(1'b0, 1'b0, e);
    scan(1'b0, '0, 32, d);
    check(d, {38'h0, 4'h0, DEPTH, WIDTH, 6'h00, MFR, 1'b1});
    $display("test ident done");
    apb(1'b0, scan_pkg::ADDR_CONFIG, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b1, scan_pkg::ADDR_CONFIG, 32'h0000_02A9, r, e);
    apb(1'b0, scan_pkg::ADDR_CONFIG, 32'h0, r, e);
    check({e, r}, 33'h0_0000_02A9);
    apb(1'b0, 32'h0000_0008, 32'h0, r, e);
    check({e, r}, 33'h1_0000_0000);
    scan(1'b0, '0, 32, d);
    check(d, {38'h0, 4'h9, DEPTH, WIDTH, 6'h2A, MFR, 1'b1});
    $display("test config done");
    foreach (codes[i]) begin
      scan(1'b1, {67'h0, codes[i]}, 3, d);
      check(d[1:0], 2'h1);
      hz = codes[i] == scan_pkg::INS_CAPTURE_HIZ || codes[i] == scan_pkg::INS_SAMPLE_HIZ;
      apb(1'b0, scan_pkg::ADDR_STATUS, 32'h0, r, e);
      check({hiz, r[3:0]}, {hz, hz, codes[i]});
      if (codes[i] == scan_pkg::INS_BYPASS) begin
        scan(1'b0, 70'hB, 4, d);
        check(d, 70'h6);
      end else begin
        scan(1'b0, '0, 70, d);
        check(d, {pads[67:52], 1'b0, pads[51:29], 1'b0, pads[28:0]});
      end
      $display("test code %0h done", codes[i]);
    end
    scan(1'b1, {67'h0, scan_pkg::INS_IDENT}, 3, d);
    scan(1'b0, '0, 32, d);
    check(d, {38'h0, 4'h9, DEPTH, WIDTH, 6'h2A, MFR, 1'b1});
    scan(1'b1, {67'h0, scan_pkg::INS_SAMPLE_HIZ}, 3, d);
    check(hiz, 1'b1);
    $display("test reload done");
    repeat (3) jtag_ctrl_inst.step(1'b1, 1'b0, e);
    apb(1'b0, scan_pkg::ADDR_STATUS, 32'h0, r, e);
    check({hiz, r[19:0]}, {1'b0, scan_pkg::ST_RESET, 1'b0, scan_pkg::INS_IDENT});
    $display("test reset state done");
    complete_run();
  end
endmodule
